/* src/ocsw_cfg.svh */
// constants of the octal switch serial control block
// assumes a 100 MHz system clock; included by name from src/
`ifndef OCSW_CFG_SVH
`define OCSW_CFG_SVH

`define OCSW_CLK_MHZ 100
`define OCSW_CHANNELS 8
`define OCSW_PAR_CHANNELS 4
`define OCSW_FRAME_BITS 16
`define OCSW_FRAME_PULSES 5'h10
`define OCSW_PULSE_MAX 5'h1F
`define OCSW_CTRL_DIAG_ONLY 8'h00
`define OCSW_CTRL_MSB 15
`define OCSW_CTRL_LSB 8
`define OCSW_DATA_MSB 7
`define OCSW_DATA_LSB 0
`define OCSW_OUT_RST 8'h00
`define OCSW_RX_RST 16'h0000
`define OCSW_DIAG_NORMAL 2'h3
`define OCSW_DIAG_OVERLOAD 2'h2
`define OCSW_DIAG_OPEN_LOAD 2'h1
`define OCSW_DIAG_SHORT_GND 2'h0
`define OCSW_DIAG_RST 16'hFFFF
// thermal restart pattern: period and on time, microseconds
`define OCSW_OT_PERIOD_US 1000
`define OCSW_OT_ON_US 50

`endif

/* src/ocsw_pkg.sv */
// types shared by the octal switch serial control block
// assumes the constants header sits beside it
package ocsw_pkg;

    // per-channel sense flags from the analog power stages
    typedef struct packed {
        logic [7:0] overtemp;
        logic [7:0] overload;
        logic [7:0] open_load;
        logic [7:0] short_gnd;
    } ocsw_sense_t;

    // serial link pins as seen by the device
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } ocsw_spi_in_t;

    // synchronised bundle of every asynchronous input
    typedef struct packed {
        logic polarity;
        logic [3:0] par_in;
        ocsw_spi_in_t spi;
        ocsw_sense_t sense;
    } ocsw_async_t;

endpackage

/* src/ocsw_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no word coherence
`timescale 1ns/10ps
module ocsw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // ocsw_sync

/* src/ocsw_spi_ctrl.sv */
// serial control and diagnosis logic of an eight channel low-side switch
// assumes pins and sense flags are asynchronous; sclk well below sys_clk/4
//
// Contract
// - ch1-4 on only if parallel and serial high
// - parallel inputs polarity follows select pin
// - overload or supply short reports high-low code
// - overtemperature channel runs low duty restart pattern
// - chip select fall loads diagnosis, drives output
// - valid frame end updates outputs, clears diagnosis
// - deselected: ignore clock and data, output floats
// - accept only frames of exactly 16 pulses
// - sample input on fall, shift output on rise
// - frames and diagnosis travel msb first
// - high data bit turns channel on, gated
// - reset clears shift register, outputs off
// - fault flag low when any channel faulted
// - faults latch, newer overwrites older per channel
// - codes: normal, overload, open load, ground short
// - control zero: keep outputs, still shift diagnosis
// - any nonzero control byte applies data byte
// - high bit on, low bit off
`timescale 1ns/10ps
`include "ocsw_cfg.svh"
module ocsw_spi_ctrl #(
    parameter int OT_PERIOD_CYC = `OCSW_OT_PERIOD_US * `OCSW_CLK_MHZ,
    parameter int OT_ON_CYC = `OCSW_OT_ON_US * `OCSW_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire ocsw_pkg::ocsw_spi_in_t spi_in,
    output logic spi_so_o,
    output logic spi_so_oe,
    input wire logic input_polarity_select,
    input wire logic parallel_drive_input_1,
    input wire logic parallel_drive_input_2,
    input wire logic parallel_drive_input_3,
    input wire logic parallel_drive_input_4,
    input wire ocsw_pkg::ocsw_sense_t ch_sense,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic power_output_1,
    output logic power_output_2,
    output logic power_output_3,
    output logic power_output_4,
    output logic power_output_5,
    output logic power_output_6,
    output logic power_output_7,
    output logic power_output_8
);
    import ocsw_pkg::*;

    localparam int NCH = `OCSW_CHANNELS;
    localparam int NPAR = `OCSW_PAR_CHANNELS;
    localparam int NBIT = `OCSW_FRAME_BITS;

    ocsw_async_t raw;
    ocsw_async_t syn;

    assign raw.polarity = input_polarity_select;
    assign raw.par_in = {parallel_drive_input_4, parallel_drive_input_3,
                         parallel_drive_input_2, parallel_drive_input_1};
    assign raw.spi = spi_in;
    assign raw.sense = ch_sense;

    // deselected and no faults while the synchroniser fills
    localparam ocsw_async_t SYNC_RST = '{
        polarity: 1'b0,
        par_in: 4'h0,
        spi: '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0},
        sense: '0
    };

    ocsw_sync #(
        .W($bits(ocsw_async_t)),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(raw),
        .q(syn)
    );

    // edge detection on the synchronised link pins
    logic sclk_d_reg;
    logic cs_n_d_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_act;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= syn.spi.sclk;
            cs_n_d_reg <= syn.spi.cs_n;
        end
    end

    assign cs_act = !syn.spi.cs_n;
    assign cs_fall = cs_n_d_reg && !syn.spi.cs_n;
    assign cs_rise = !cs_n_d_reg && syn.spi.cs_n;
    // clock edges only count while selected and away from select edges
    assign sclk_rise = cs_act && !cs_n_d_reg && syn.spi.sclk
                       && !sclk_d_reg;
    assign sclk_fall = cs_act && !cs_n_d_reg && !syn.spi.sclk
                       && sclk_d_reg;

    // receive shift register and pulse counter
    logic [NBIT-1:0] rx_reg;
    logic [4:0] pulse_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_reg <= `OCSW_RX_RST;
        end else if (sclk_fall) begin
            rx_reg <= {rx_reg[NBIT-2:0], syn.spi.si};
        end
    end

    // saturates so that very long frames never wrap back to 16
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_fall) begin
            pulse_reg <= 5'h00;
        end else if (sclk_fall && pulse_reg != `OCSW_PULSE_MAX) begin
            pulse_reg <= pulse_reg + 5'h01;
        end
    end

    logic frame_ok;
    logic ctrl_valid;
    assign frame_ok = cs_rise
                      && (pulse_reg == `OCSW_FRAME_PULSES);
    assign ctrl_valid = rx_reg[`OCSW_CTRL_MSB:`OCSW_CTRL_LSB]
                        != `OCSW_CTRL_DIAG_ONLY;

    // output control buffer
    logic [NCH-1:0] ctrl_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `OCSW_OUT_RST;
        end else if (frame_ok && ctrl_valid) begin
            ctrl_reg <= rx_reg[`OCSW_DATA_MSB:`OCSW_DATA_LSB];
        end
    end

    // thermal restart timebase shared by all channels
    logic [31:0] ot_cnt_reg;
    logic ot_on_phase;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || ot_cnt_reg == 32'(OT_PERIOD_CYC - 1)) begin
            ot_cnt_reg <= 32'h0;
        end else begin
            ot_cnt_reg <= ot_cnt_reg + 32'h1;
        end
    end

    assign ot_on_phase = ot_cnt_reg < 32'(OT_ON_CYC);

    // per channel drive gating and diagnosis latch
    logic [NCH-1:0] out_next;
    logic [NCH-1:0] out_reg;
    logic [2*NCH-1:0] diag_reg;
    logic [NCH-1:0] fault_now;
    logic [2*NCH-1:0] code_now;
    logic par_active [NPAR];

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic gate;
            if (ch < NPAR) begin : g_par
                // polarity select high: active high inputs
                assign par_active[ch] = syn.polarity ? syn.par_in[ch]
                                        : !syn.par_in[ch];
                assign gate = par_active[ch];
            end else begin : g_ser
                assign gate = 1'b1;
            end

            // overheated channels only conduct in the short on phase
            assign out_next[ch] = ctrl_reg[ch]
                && gate
                && (!syn.sense.overtemp[ch] || ot_on_phase);

            always_comb begin
                if (syn.sense.overtemp[ch] || syn.sense.overload[ch]) begin
                    code_now[2*ch+:2] = `OCSW_DIAG_OVERLOAD;
                end else if (syn.sense.short_gnd[ch]) begin
                    code_now[2*ch+:2] = `OCSW_DIAG_SHORT_GND;
                end else if (syn.sense.open_load[ch]) begin
                    code_now[2*ch+:2] = `OCSW_DIAG_OPEN_LOAD;
                end else begin
                    code_now[2*ch+:2] = `OCSW_DIAG_NORMAL;
                end
            end

            assign fault_now[ch] = code_now[2*ch+:2] != `OCSW_DIAG_NORMAL;

            // a fault present in the clearing cycle is kept
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    diag_reg[2*ch+:2] <= `OCSW_DIAG_NORMAL;
                end else if (fault_now[ch]) begin
                    diag_reg[2*ch+:2] <= code_now[2*ch+:2];
                end else if (frame_ok) begin
                    diag_reg[2*ch+:2] <= `OCSW_DIAG_NORMAL;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_reg <= `OCSW_OUT_RST;
        end else begin
            out_reg <= out_next;
        end
    end

    assign {power_output_8, power_output_7, power_output_6, power_output_5,
            power_output_4, power_output_3, power_output_2,
            power_output_1} = out_reg;

    // fault flag: open drain, pulled low while anything is reported
    logic fault_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= (diag_reg != `OCSW_DIAG_RST)
                         || (|fault_now);
        end
    end

    assign fault_n_o = 1'b0;
    assign fault_n_oe = fault_reg;

    // transmit shift register; channel 8 pair sits in the top bits
    logic [NBIT-1:0] tx_reg;
    logic first_reg;
    logic so_oe_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_reg <= `OCSW_DIAG_RST;
            first_reg <= 1'b0;
        end else if (cs_fall) begin
            tx_reg <= diag_reg;
            first_reg <= 1'b1;
        end else if (sclk_rise) begin
            // the msb stays for the first rising edge so the master
            // can take it on the first falling edge
            first_reg <= 1'b0;
            if (!first_reg) begin
                tx_reg <= {tx_reg[NBIT-2:0], 1'b1};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= cs_act;
        end
    end

    assign spi_so_o = tx_reg[NBIT-1];
    assign spi_so_oe = so_oe_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_so_hiz_idle: assert property (
        !cs_act |=> !spi_so_oe)
        else $error("serial output driven while deselected");

    a_diag_load: assert property (
        cs_fall |=> tx_reg == $past(diag_reg) && spi_so_oe)
        else $error("diagnosis not loaded on select fall");

    a_frame_accept: assert property (
        frame_ok && ctrl_valid |=> ctrl_reg == $past(rx_reg[7:0]))
        else $error("valid frame not applied");

    a_diag_only_hold: assert property (
        cs_rise && !ctrl_valid |=> $stable(ctrl_reg))
        else $error("diagnosis only frame changed outputs");

    a_bad_count: assert property (
        cs_rise && pulse_reg != `OCSW_FRAME_PULSES |=> $stable(ctrl_reg))
        else $error("frame with wrong pulse count accepted");

    a_rx_sample: assert property (
        sclk_fall |=> rx_reg[0] == $past(syn.spi.si))
        else $error("input bit not sampled on falling edge");

    a_par_gate: assert property (
        !par_active[0] |=> !power_output_1)
        else $error("channel 1 on with parallel input inactive");

    a_overload_code: assert property (
        syn.sense.overload[0] |=> diag_reg[1:0] == `OCSW_DIAG_OVERLOAD)
        else $error("overload not reported as high-low");

    a_fault_flag: assert property (
        |fault_now |=> fault_n_oe ##0 !fault_n_o)
        else $error("fault flag not pulled low");

    a_reset_off: assert property (
        disable iff (1'b0) !rst_n |=> out_reg == 8'h00 && rx_reg == 16'h0000)
        else $error("reset did not clear outputs");

    c_frame_accept: cover property (frame_ok && ctrl_valid);
    c_diag_only: cover property (frame_ok && !ctrl_valid);
    c_bad_frame: cover property (cs_rise && !frame_ok);
    c_thermal: cover property (|(syn.sense.overtemp & ctrl_reg));
endmodule // ocsw_spi_ctrl

/* verif/ocsw_master_model.sv */
// serial master model driving the link pins of the switch block
// assumes the bench resolves the tri-state data out line into so
`timescale 1ns/10ps
module ocsw_master_model (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // one frame of n pulses at a 125 ns clock; bits beyond 16 are junk
    task automatic frame(input logic [15:0] w, input int n,
                         output logic [15:0] rx);
        rx = 16'h0000;
        cs_n <= 1'b0;
        #125;
        for (int i = 0; i < n; i++) begin
            si <= (i < 16) ? w[15 - i] : ~si;
            #31;
            sclk <= 1'b1;
            #62;
            if (i < 16)
                rx[15 - i] = so;
            sclk <= 1'b0;
            #32;
        end
        #125;
        cs_n <= 1'b1;
        si <= ~si;
        #250;
    endtask

    // clock and data activity while deselected
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            si <= ~si;
            #62 sclk <= ~sclk;
        end
        #62 sclk <= 1'b0;
        #100;
    endtask
endmodule // ocsw_master_model

/* verif/octal_switch_spi_control_test.sv */
// self-checking bench of the octal switch serial control block
// assumes the design package, header and master model are compiled first
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module octal_switch_spi_control_test;
    import ocsw_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pol = 1'b1;
    logic [3:0] par = 4'hF;
    ocsw_sense_t sense = '0;
    ocsw_sense_t s;
    ocsw_spi_in_t spi;
    logic m_cs_n, m_sclk, m_si, so_o, so_oe, so, flt_o, flt_oe;
    logic [7:0] cur, cnt;
    wire [7:0] outs;
    wire flt_n;
    logic [15:0] rx;
    int bad_count = 0;
    int num_checks = 0;

    always #5 sys_clk = ~sys_clk;
    assign spi = {m_cs_n, m_sclk, m_si};
    // released line shows the inverse so a stray sample mismatches
    assign so = so_oe ? so_o : ~so_o;
    // open drain fault line with its pull-up
    assign flt_n = flt_oe ? flt_o : 1'b1;

    ocsw_master_model M (.cs_n(m_cs_n), .sclk(m_sclk), .si(m_si), .so(so));

    ocsw_spi_ctrl #(.OT_PERIOD_CYC(40), .OT_ON_CYC(4)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_in(spi),
        .spi_so_o(so_o), .spi_so_oe(so_oe), .input_polarity_select(pol),
        .parallel_drive_input_1(par[0]), .parallel_drive_input_2(par[1]),
        .parallel_drive_input_3(par[2]), .parallel_drive_input_4(par[3]),
        .ch_sense(sense), .fault_n_o(flt_o), .fault_n_oe(flt_oe),
        .power_output_1(outs[0]), .power_output_2(outs[1]),
        .power_output_3(outs[2]), .power_output_4(outs[3]),
        .power_output_5(outs[4]), .power_output_6(outs[5]),
        .power_output_7(outs[6]), .power_output_8(outs[7])
    );

    function automatic logic [7:0] gate(logic [7:0] d, logic [3:0] p,
                                       logic pl);
        return {d[7:4], d[3:0] & (pl ? p : ~p)};
    endfunction

    function automatic logic [15:0] diag(ocsw_sense_t v);
        logic [15:0] w;
        for (int k = 0; k < 8; k++)
            w[2*k +: 2] = (v.overload[k] | v.overtemp[k]) ? 2'h2 :
                v.short_gnd[k] ? 2'h0 : v.open_load[k] ? 2'h1 : 2'h3;
        return w;
    endfunction

    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic send(logic [7:0] c, logic [7:0] d, int n);
        M.frame({c, d}, n, rx);
        if (n == 16 && c != 8'h00)
            cur = d;
        @(negedge sys_clk);
        `CHK(outs, gate(cur, par, pol))
        if (n >= 16)
            `CHK(rx, 16'hFFFF)
    endtask

    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h1F13344E));
        cur = 8'h00;
        repeat (8) @(posedge sys_clk);
        `CHK(outs, 8'h00)
        `CHK(so_oe, 1'b0)
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        for (int i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            pol <= 1'($urandom);
            par <= 4'($urandom);
            send(i < 2 ? 8'hFF : 8'(($urandom % 255) + 1), 8'($urandom), 16);
        end
        send(8'h00, ~cur, 16);
        send(8'hFF, ~cur, 15);
        send(8'hFF, ~cur, 17);
        @(posedge sys_clk);
        par <= ~par;
        repeat (8) @(posedge sys_clk);
        `CHK(outs, gate(cur, par, pol))
        M.noise(20);
        `CHK(outs, gate(cur, par, pol))
        `CHK(so_oe, 1'b0)
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK(outs, 8'h00)
        cur = 8'h00;
        rst_n <= 1'b1;
        pol <= 1'b1;
        par <= 4'hF;
        repeat (6) @(posedge sys_clk);
        for (int j = 0; j < 4; j++) begin
            s = '0;
            s[8*j + ($urandom % 8)] = 1'b1;
            @(posedge sys_clk);
            sense <= s;
            repeat (10) @(posedge sys_clk);
            `CHK(flt_n, 1'b0)
            sense <= '0;
            @(posedge sys_clk);
            M.frame(16'h0000, 16, rx);
            `CHK(rx, diag(s))
            M.frame(16'h0000, 16, rx);
            `CHK(rx, 16'hFFFF)
            `CHK(flt_n, 1'b1)
        end
        send(8'hFF, 8'hFF, 16);
        @(posedge sys_clk);
        sense <= 32'h10000000;
        repeat (12) @(posedge sys_clk);
        cnt = 8'h00;
        for (int t = 0; t < 40; t++) begin
            @(posedge sys_clk);
            #1 cnt = cnt + 8'(outs[4]);
            `CHK(outs[5], 1'b1)
        end
        `CHK(cnt, 8'h04)
        print_verdict();
    end
endmodule // octal_switch_spi_control_test
